/* hdl/acr_pkg.sv */
// shared constants and types for the converter control block
package acr_pkg;
  // register word indices; byte address is four times the index
  localparam logic [5:0] IDX_DID_LOW = 6'h01;
  localparam logic [5:0] IDX_DID_HIGH = 6'h02;
  localparam logic [5:0] IDX_CTL_B = 6'h03;
  localparam logic [5:0] IDX_RES_LOW = 6'h04;
  localparam logic [5:0] IDX_RES_HIGH = 6'h05;
  localparam logic [5:0] IDX_CTL_A = 6'h06;
  localparam logic [5:0] IDX_MUX = 6'h07;
  // control a field positions
  localparam int CA_EN = 7;
  localparam int CA_SC = 6;
  localparam int CA_ATE = 5;
  localparam int CA_FLAG = 4;
  localparam int CA_IE = 3;
  // control b field positions
  localparam int CB_BIPOLAR = 7;
  localparam int CB_GAIN_HIGH = 6;
  localparam int CB_REF_HIGH = 4;
  localparam int CB_CHAN_MSB = 3;
  // channel mux and input disable register field positions
  localparam int MX_ALIGN = 5;
  localparam int DID_AREF = 3;
  // writable masks, reset values and saturated result value
  localparam logic [7:0] DID_HIGH_MASK = 8'hF0;
  localparam logic [7:0] CTL_B_MASK = 8'hDF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [9:0] RES_FULL_SCALE = 10'h3FF;
  // conversion lengths in converter clock cycles
  localparam logic [4:0] CONV_NORMAL = 5'h0D;
  localparam logic [4:0] CONV_FIRST = 5'h19;

  typedef struct packed {
    logic en;
    logic ate;
    logic flag;
    logic ie;
    logic [2:0] ps;
  } acr_ctla_s;

  typedef enum logic {ACR_IDLE, ACR_RUN} acr_state_e;
endpackage

/* hdl/acr_conv_ctrl.sv */
// control, prescaler, trigger and result registers of the converter
//
// Functional notes
// - done flag sets when result is stored
// - interrupt needs enable, global enable, flag
// - vectoring to handler clears done flag
// - write one clears flag, zero keeps
// - divider select picks 2 to 128
// - low byte read locks result until high
// - left align moves result into high byte
// - bipolar gives two's complement, else unsigned
// - unipolar negative differential saturates full scale
// - high gain select swaps gain pairs
// - control b bit five reads zero
// - high reference bit picks internal reference
// - channel changes wait for conversion end
// - auto trigger starts on selected rising edge
// - switching to set source counts as edge
// - switching to free running never triggers
// - trigger codes map to fixed sources
// - channel disable gates low pin inputs
// - reference pin disable gates its input
// - high disable bits gate channels seven-ten
// - conversion 13 cycles, first one 25
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module acr_conv_ctrl (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic GIE,
  input wire logic IRQ_ACK,
  input wire logic [7:1] TRIG_FLAGS,
  input wire logic [9:0] ANA_RESULT,
  input wire logic ANA_BELOW,
  input wire logic [11:0] PIN_RAW,
  output logic SAMPLE_START,
  output logic CONV_ACTIVE,
  output logic CONV_CLK,
  output logic [5:0] MUX_SEL,
  output logic [2:0] REF_SEL,
  output logic BIPOLAR,
  output logic GAIN_HIGH,
  output logic [11:0] DIN_OFF,
  output logic [11:0] PIN_VAL,
  output logic IRQ
);

  // low-bit mask of the prescaler counter for a divider select code
  function automatic logic [6:0] div_mask(input logic [2:0] ps);
    logic [7:0] full;
    full = 8'h01 << ps;
    div_mask = (ps == 3'h0) ? 7'h01 : 7'(full - 8'h01);
  endfunction

  // codes that route a differential pair through the gain stage
  function automatic logic is_diff(input logic [5:0] m);
    is_diff = ((m >= 6'h0B) && (m <= 6'h1D)) || ((m >= 6'h20) && (m != 6'h3F));
  endfunction

  acr_pkg::acr_ctla_s ctla_q;
  acr_pkg::acr_state_e st_q;
  logic [7:0] ctlb_q;
  logic [7:0] mux_q;
  logic [7:0] did_lo_q;
  logic [7:0] did_hi_q;
  logic [9:0] res_q;
  logic lock_q;
  logic init_q;
  logic [6:0] pre_q;
  logic [4:0] cnt_q;
  logic [4:0] tgt_q;
  logic [5:0] mux_eff_q;
  logic trig_prev_q;
  logic [2:0] tsel_prev_q;
  logic [11:0] pin_s1_q;
  logic [11:0] pin_s2_q;

  // bus decode
  wire [5:0] widx = PADDR[7:2];
  wire idx_ok = (widx == acr_pkg::IDX_DID_LOW) || (widx == acr_pkg::IDX_DID_HIGH)
    || (widx == acr_pkg::IDX_CTL_B) || (widx == acr_pkg::IDX_RES_LOW)
    || (widx == acr_pkg::IDX_RES_HIGH) || (widx == acr_pkg::IDX_CTL_A)
    || (widx == acr_pkg::IDX_MUX);
  wire hit_w = idx_ok && (PADDR[1:0] == 2'b00);
  wire setup_w = PSEL && PENABLE && !PREADY;
  wire acc_w = PSEL && PENABLE && PREADY && hit_w;
  wire wr_w = acc_w && PWRITE;
  wire rd_w = acc_w && !PWRITE;
  wire wr_ctla = wr_w && (widx == acr_pkg::IDX_CTL_A);
  wire wr_ctlb = wr_w && (widx == acr_pkg::IDX_CTL_B);
  wire wr_mux = wr_w && (widx == acr_pkg::IDX_MUX);
  wire wr_dlo = wr_w && (widx == acr_pkg::IDX_DID_LOW);
  wire wr_dhi = wr_w && (widx == acr_pkg::IDX_DID_HIGH);
  wire rd_rlo = rd_w && (widx == acr_pkg::IDX_RES_LOW);
  wire rd_rhi = rd_w && (widx == acr_pkg::IDX_RES_HIGH);
  wire [7:0] wdat = PWDATA[7:0];

  // result formatting by alignment; uncovered bits read zero
  wire align = mux_q[acr_pkg::MX_ALIGN];
  wire [7:0] res_lo_w = align ? {res_q[1:0], 6'h00} : res_q[7:0];
  wire [7:0] res_hi_w = align ? res_q[9:2] : {6'h00, res_q[9:8]};

  // read data selection; start bit shows a conversion in flight
  wire [7:0] ctla_rd = {ctla_q.en, (st_q == acr_pkg::ACR_RUN), ctla_q.ate,
    ctla_q.flag, ctla_q.ie, ctla_q.ps};
  wire [7:0] rd_byte =
    (widx == acr_pkg::IDX_CTL_A) ? ctla_rd :
    (widx == acr_pkg::IDX_CTL_B) ? (ctlb_q & acr_pkg::CTL_B_MASK) :
    (widx == acr_pkg::IDX_MUX) ? mux_q :
    (widx == acr_pkg::IDX_RES_LOW) ? res_lo_w :
    (widx == acr_pkg::IDX_RES_HIGH) ? res_hi_w :
    (widx == acr_pkg::IDX_DID_LOW) ? did_lo_q :
    (widx == acr_pkg::IDX_DID_HIGH) ? (did_hi_q & acr_pkg::DID_HIGH_MASK) :
    8'h00;

  // prescaler tick: one system clock per converter clock
  wire tick_w = ctla_q.en && ((pre_q & div_mask(ctla_q.ps)) == div_mask(ctla_q.ps));

  // trigger source and edge; the free running source is the done flag
  // limitation: an edge that arrives while a conversion runs is dropped, not queued
  wire [2:0] tsel = ctlb_q[2:0];
  wire [7:0] trig_vec = {TRIG_FLAGS, ctla_q.flag};
  wire trig_sig = trig_vec[tsel];
  wire to_free_w = (tsel == 3'h0) && (tsel_prev_q != 3'h0);
  wire edge_w = trig_sig && !trig_prev_q && !to_free_w;
  wire auto_w = ctla_q.ate && ctla_q.en && edge_w;

  // start requests and conversion end
  wire sw_w = wr_ctla && wdat[acr_pkg::CA_SC] && wdat[acr_pkg::CA_EN];
  wire idle_w = (st_q == acr_pkg::ACR_IDLE);
  wire start_w = idle_w && (sw_w || auto_w);
  wire done_w = (st_q == acr_pkg::ACR_RUN) && ctla_q.en && tick_w
    && (cnt_q == 5'(tgt_q - 5'h01));
  wire en_next = wr_ctla ? wdat[acr_pkg::CA_EN] : ctla_q.en;

  // unipolar differential below zero saturates, bipolar passes through
  wire sat_w = !ctlb_q[acr_pkg::CB_BIPOLAR] && ANA_BELOW && is_diff(mux_eff_q);
  wire [9:0] conv_w = sat_w ? acr_pkg::RES_FULL_SCALE : ANA_RESULT;

  // flag: hardware set beats any clear in the same cycle
  // a clear meeting the done pulse loses, so no finished result goes unflagged
  wire flag_clr = (wr_ctla && wdat[acr_pkg::CA_FLAG]) || IRQ_ACK;
  wire flag_d = done_w || (ctla_q.flag && !flag_clr);

  // apb slave: one wait state, data and error registered
  // the response is formed at the first access edge, so the second only commits
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= setup_w;
      if (setup_w) begin
        PRDATA <= hit_w ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        PSLVERR <= !hit_w;
      end
    end
  end

  // control a; software clears only by writing one to the flag
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctla_q <= '0;
    end else if (CE) begin
      if (wr_ctla) begin
        ctla_q.en <= wdat[acr_pkg::CA_EN];
        ctla_q.ate <= wdat[acr_pkg::CA_ATE];
        ctla_q.ie <= wdat[acr_pkg::CA_IE];
        ctla_q.ps <= wdat[2:0];
      end
      ctla_q.flag <= flag_d;
    end
  end

  // control b, channel mux and input disable registers
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctlb_q <= acr_pkg::RESET_BYTE;
      mux_q <= acr_pkg::RESET_BYTE;
      did_lo_q <= acr_pkg::RESET_BYTE;
      did_hi_q <= acr_pkg::RESET_BYTE;
    end else if (CE) begin
      if (wr_ctlb) ctlb_q <= wdat & acr_pkg::CTL_B_MASK;
      if (wr_mux) mux_q <= wdat;
      if (wr_dlo) did_lo_q <= wdat;
      if (wr_dhi) did_hi_q <= wdat & acr_pkg::DID_HIGH_MASK;
    end
  end

  // conversion sequencer; turning the converter off aborts it
  // init_q marks that the next start must run the long first conversion
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_q <= acr_pkg::ACR_IDLE;
      cnt_q <= 5'h00;
      tgt_q <= acr_pkg::CONV_NORMAL;
      init_q <= 1'b1;
    end else if (CE) begin
      unique case (st_q)
        acr_pkg::ACR_IDLE: begin
          if (start_w) begin
            st_q <= acr_pkg::ACR_RUN;
            cnt_q <= 5'h00;
            tgt_q <= init_q ? acr_pkg::CONV_FIRST : acr_pkg::CONV_NORMAL;
            init_q <= 1'b0;
          end else if (!en_next) begin
            init_q <= 1'b1;
          end
        end
        acr_pkg::ACR_RUN: begin
          if (!en_next || done_w) begin
            st_q <= acr_pkg::ACR_IDLE;
            init_q <= !en_next;
          end else if (tick_w) begin
            cnt_q <= 5'(cnt_q + 5'h01);
          end
        end
      endcase
    end
  end

  // prescaler runs only while the converter is enabled
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pre_q <= 7'h00;
    end else if (CE) begin
      pre_q <= ctla_q.en ? 7'(pre_q + 7'h01) : 7'h00;
    end
  end

  // result pair; a pending low-byte read holds off new results
  // trade-off: a result finished while locked is lost rather than tearing the pair
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      res_q <= 10'h000;
      lock_q <= 1'b0;
    end else if (CE) begin
      if (done_w && !lock_q) res_q <= conv_w;
      if (rd_rlo) lock_q <= 1'b1;
      else if (rd_rhi) lock_q <= 1'b0;
    end
  end

  // channel select takes effect only between conversions
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mux_eff_q <= 6'h00;
    end else if (CE) begin
      if (idle_w || done_w) mux_eff_q <= {ctlb_q[acr_pkg::CB_CHAN_MSB], mux_q[4:0]};
    end
  end

  // trigger history for edge detection
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      trig_prev_q <= 1'b0;
      tsel_prev_q <= 3'h0;
    end else if (CE) begin
      trig_prev_q <= trig_sig;
      tsel_prev_q <= tsel;
    end
  end

  // pin inputs cross in through two flops before gating
  // only the second stage reads the first, so metastability stays contained
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pin_s1_q <= 12'h000;
      pin_s2_q <= 12'h000;
    end else if (CE) begin
      pin_s1_q <= PIN_RAW;
      pin_s2_q <= pin_s1_q;
    end
  end

  // disable map: bits 6:0 channels, 10:7 high channels, 11 reference pin
  wire [11:0] off_w = {did_lo_q[acr_pkg::DID_AREF], did_hi_q[7:4], did_lo_q[7:4],
    did_lo_q[2:0]};

  // analog-side and pin outputs, all registered
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      SAMPLE_START <= 1'b0;
      CONV_ACTIVE <= 1'b0;
      CONV_CLK <= 1'b0;
      MUX_SEL <= 6'h00;
      REF_SEL <= 3'h0;
      BIPOLAR <= 1'b0;
      GAIN_HIGH <= 1'b0;
      DIN_OFF <= 12'h000;
      PIN_VAL <= 12'h000;
      IRQ <= 1'b0;
    end else if (CE) begin
      SAMPLE_START <= start_w;
      CONV_ACTIVE <= !idle_w;
      CONV_CLK <= tick_w;
      MUX_SEL <= mux_eff_q;
      REF_SEL <= {ctlb_q[acr_pkg::CB_REF_HIGH], mux_q[7:6]};
      BIPOLAR <= ctlb_q[acr_pkg::CB_BIPOLAR];
      GAIN_HIGH <= ctlb_q[acr_pkg::CB_GAIN_HIGH] && mux_eff_q[5];
      DIN_OFF <= off_w;
      PIN_VAL <= pin_s2_q & ~off_w;
      IRQ <= ctla_q.ie && GIE && flag_d;
    end
  end

  // checks on the logic above
  a_done_sets_flag: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && done_w |=> ctla_q.flag) else $error("done did not set flag");
  a_irq_gating: assert property (@(posedge SYS_CLK) disable iff (RST)
    IRQ |-> $past(ctla_q.ie) && $past(GIE) && ctla_q.flag) else $error("irq without cause");
  a_ack_clears: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && IRQ_ACK && !done_w |=> !ctla_q.flag) else $error("ack left flag set");
  a_write_one_clear: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && wr_ctla && !wdat[acr_pkg::CA_FLAG] && !IRQ_ACK && ctla_q.flag |=> ctla_q.flag)
    else $error("zero write cleared flag");
  a_div_two: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && tick_w && (ctla_q.ps == 3'h1) && !wr_ctla
    |=> !tick_w ##1 (tick_w || !CE || !$past(CE) || !ctla_q.en || (ctla_q.ps != 3'h1)))
    else $error("divide by two broken");
  a_lock_holds: assert property (@(posedge SYS_CLK) disable iff (RST)
    lock_q && done_w |=> $stable(res_q)) else $error("locked result changed");
  a_align_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && setup_w && hit_w && (widx == acr_pkg::IDX_RES_LOW) && align
    |=> PRDATA[5:0] == 6'h00) else $error("unused low bits not zero");
  a_reserved_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    ctlb_q[5] == 1'b0) else $error("reserved bit set");
  a_mux_defer: assert property (@(posedge SYS_CLK) disable iff (RST)
    !idle_w && !done_w |=> $stable(mux_eff_q)) else $error("channel changed mid run");
  a_no_auto_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    !ctla_q.ate |-> !auto_w) else $error("auto start while disabled");
  a_free_switch: assert property (@(posedge SYS_CLK) disable iff (RST)
    to_free_w |-> !auto_w) else $error("free running switch triggered");
  a_pin_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    (PIN_VAL & DIN_OFF) == 12'h000) else $error("disabled pin reads one");
  a_first_len: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && start_w && init_q |=> tgt_q == acr_pkg::CONV_FIRST) else $error("first conversion length");

  // further checks on flag priority, result path and outputs
  a_set_wins: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && done_w && flag_clr |=> ctla_q.flag) else $error("clear beat flag set");
  a_lock_set: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && rd_rlo |=> lock_q) else $error("low read did not lock");
  a_bipolar_raw: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && done_w && !lock_q && ctlb_q[acr_pkg::CB_BIPOLAR] |=> res_q == $past(ANA_RESULT))
    else $error("bipolar result altered");
  a_sat_value: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && done_w && !lock_q && sat_w |=> res_q == acr_pkg::RES_FULL_SCALE)
    else $error("unipolar result not saturated");
  a_gain_diff: assert property (@(posedge SYS_CLK) disable iff (RST)
    GAIN_HIGH |-> MUX_SEL[5]) else $error("high gain on plain channel");
  a_ref_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE |=> REF_SEL[2] == $past(ctlb_q[acr_pkg::CB_REF_HIGH]))
    else $error("reference select lag");
  a_edge_start: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && idle_w && auto_w |=> st_q == acr_pkg::ACR_RUN) else $error("edge did not start");
  a_did_high_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    did_hi_q[3:0] == 4'h0) else $error("unused disable bits set");
  a_normal_len: assert property (@(posedge SYS_CLK) disable iff (RST)
    CE && start_w && !init_q |=> tgt_q == acr_pkg::CONV_NORMAL)
    else $error("normal conversion length");

endmodule

`default_nettype wire

/* testbench/acr_conv_ctrl_tb_top.sv */
// self-checking bench for the converter control block over its register bus
`timescale 1ns/1ps
`default_nettype none
module acr_conv_ctrl_tb_top;
  logic sys_clk, rst, ce, psel, penable, pwrite, gie, irq_ack, ana_below;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, sample_start, conv_active, conv_clk, bipolar, gain_high, irq;
  logic [7:1] trig_flags;
  logic [9:0] ana_result;
  logic [11:0] pin_raw, din_off, pin_val;
  logic [5:0] mux_sel;
  logic [2:0] ref_sel;
  logic [7:0] rd_q;
  logic err_q;
  int miscompares = 0;
  int checked = 0;

  acr_conv_ctrl dut (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .GIE(gie), .IRQ_ACK(irq_ack), .TRIG_FLAGS(trig_flags),
    .ANA_RESULT(ana_result), .ANA_BELOW(ana_below), .PIN_RAW(pin_raw),
    .SAMPLE_START(sample_start), .CONV_ACTIVE(conv_active), .CONV_CLK(conv_clk),
    .MUX_SEL(mux_sel), .REF_SEL(ref_sel), .BIPOLAR(bipolar), .GAIN_HIGH(gain_high),
    .DIN_OFF(din_off), .PIN_VAL(pin_val), .IRQ(irq));

  // 50 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  // one bus transfer; request held until ready is sampled high, bounded wait
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_q = prdata[7:0];
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: bus never ready", $time);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk_val({4'h0, rd_q}, {4'h0, exp});
  endtask

  // follow one conversion to its end; tick count and spacing checked when asked
  task automatic conv_wait(input logic [2:0] ps, input int exp_ticks);
    int ticks, gap, last, cyc;
    logic seen;
    ticks = 0;
    gap = 0;
    last = -1;
    seen = 1'b0;
    for (cyc = 0; cyc < 4000; cyc++) begin
      @(posedge sys_clk);
      if (conv_active === 1'b1) begin
        seen = 1'b1;
        if (conv_clk === 1'b1) begin
          if (last >= 0) gap = cyc - last;
          last = cyc;
          ticks++;
        end
      end else if (seen) break;
    end
    if (cyc >= 4000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: conversion never ended", $time);
      end_of_test();
    end
    if (exp_ticks != 0) begin
      chk_val(12'(ticks), 12'(exp_ticks));
      chk_val(12'(gap), (ps < 3'h2) ? 12'h002 : (12'h001 << ps));
    end
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic conv(input logic [2:0] ps, input int exp_ticks, input logic [9:0] res);
    ana_result <= res;
    wr(acr_pkg::IDX_CTL_A, 8'hC0 | {5'h00, ps});
    conv_wait(ps, exp_ticks);
  endtask

  // watch a short window for a conversion start
  task automatic expect_start(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(posedge sys_clk);
      if (sample_start === 1'b1) seen = 1'b1;
    end
    chk_bit(seen, exp);
  endtask

  // main sequence
  initial begin
    rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h00000000; gie = 1'b0; irq_ack = 1'b0;
    trig_flags = 7'h00; ana_result = 10'h000; ana_below = 1'b0; pin_raw = 12'h000;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 1; i < 8; i++) rdchk(6'(i), acr_pkg::RESET_BYTE);
    apb(1'b0, 6'h00, 8'h00);
    chk_bit(err_q, 1'b1);
    // input disable gating of pin levels
    pin_raw <= 12'hFFF;
    wr(acr_pkg::IDX_DID_LOW, 8'hFF);
    wr(acr_pkg::IDX_DID_HIGH, 8'hFF);
    rdchk(acr_pkg::IDX_DID_HIGH, 8'hF0);
    repeat (4) @(posedge sys_clk);
    chk_val(pin_val, 12'h000);
    wr(acr_pkg::IDX_DID_LOW, 8'h08);
    wr(acr_pkg::IDX_DID_HIGH, 8'h10);
    repeat (4) @(posedge sys_clk);
    chk_val(din_off, 12'h880);
    chk_val(pin_val, 12'h77F);
    // control b fields, reserved bit
    wr(acr_pkg::IDX_CTL_B, 8'hFF);
    rdchk(acr_pkg::IDX_CTL_B, 8'hDF);
    chk_bit(bipolar, 1'b1);
    chk_val({9'h000, ref_sel}, 12'h004);
    wr(acr_pkg::IDX_CTL_B, 8'h00);
    // first conversion is the long one, then alignment and lock
    conv(3'h0, 25, 10'h2A5);
    rdchk(acr_pkg::IDX_CTL_A, 8'h90);
    rdchk(acr_pkg::IDX_RES_LOW, 8'hA5);
    rdchk(acr_pkg::IDX_RES_HIGH, 8'h02);
    wr(acr_pkg::IDX_MUX, 8'h20);
    rdchk(acr_pkg::IDX_RES_LOW, 8'h40);
    rdchk(acr_pkg::IDX_RES_HIGH, 8'hA9);
    wr(acr_pkg::IDX_MUX, 8'h00);
    rdchk(acr_pkg::IDX_RES_LOW, 8'hA5);
    conv(3'h1, 13, 10'h15A);
    rdchk(acr_pkg::IDX_RES_HIGH, 8'h02);
    for (int p = 2; p < 8; p++) conv(3'(p), 13, 10'h000);
    // flag clear by writing one only
    wr(acr_pkg::IDX_CTL_A, 8'h80);
    rdchk(acr_pkg::IDX_CTL_A, 8'h90);
    wr(acr_pkg::IDX_CTL_A, 8'h90);
    rdchk(acr_pkg::IDX_CTL_A, 8'h80);
    // interrupt request needs enable, global enable and flag
    conv(3'h0, 13, 10'h001);
    gie <= 1'b1;
    wr(acr_pkg::IDX_CTL_A, 8'h88);
    repeat (3) @(posedge sys_clk);
    chk_bit(irq, 1'b1);
    gie <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk_bit(irq, 1'b0);
    gie <= 1'b1;
    irq_ack <= 1'b1;
    @(posedge sys_clk);
    irq_ack <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk_bit(irq, 1'b0);
    rdchk(acr_pkg::IDX_CTL_A, 8'h88);
    // unipolar saturation and deferred channel msb on a slow conversion
    wr(acr_pkg::IDX_MUX, 8'h0B);
    ana_below <= 1'b1;
    wr(acr_pkg::IDX_CTL_A, 8'hC7);
    wr(acr_pkg::IDX_CTL_B, 8'h08);
    repeat (3) @(posedge sys_clk);
    chk_val({6'h00, mux_sel}, 12'h00B);
    conv_wait(3'h7, 0);
    chk_val({6'h00, mux_sel}, 12'h02B);
    rdchk(acr_pkg::IDX_RES_LOW, 8'hFF);
    rdchk(acr_pkg::IDX_RES_HIGH, 8'h03);
    wr(acr_pkg::IDX_CTL_B, 8'h48);
    repeat (2) @(posedge sys_clk);
    chk_bit(gain_high, 1'b1);
    // bipolar: a differential result below zero passes through unsaturated
    wr(acr_pkg::IDX_CTL_B, 8'hC8);
    conv(3'h0, 13, 10'h2F0);
    rdchk(acr_pkg::IDX_RES_LOW, 8'hF0);
    rdchk(acr_pkg::IDX_RES_HIGH, 8'h02);
    ana_below <= 1'b0;
    // every external trigger source, codes 1 to 7, starts a conversion on its rising edge
    for (int c = 1; c < 8; c++) begin
      trig_flags <= 7'h00;
      wr(acr_pkg::IDX_CTL_B, 8'(c));
      wr(acr_pkg::IDX_CTL_A, 8'hB0);
      trig_flags[c] <= 1'b1;
      expect_start(1'b1);
      conv_wait(3'h0, 0);
    end
    trig_flags <= 7'h02;
    wr(acr_pkg::IDX_CTL_B, 8'h01);
    expect_start(1'b0);
    wr(acr_pkg::IDX_CTL_B, 8'h02);
    expect_start(1'b1);
    conv_wait(3'h0, 0);
    trig_flags <= 7'h00;
    wr(acr_pkg::IDX_CTL_B, 8'h00);
    expect_start(1'b0);
    // free running: the done flag's own rising edge restarts the converter
    wr(acr_pkg::IDX_CTL_A, 8'hF0);
    conv_wait(3'h0, 0);
    chk_bit(conv_active, 1'b1);
    // with auto trigger off the source field does nothing
    wr(acr_pkg::IDX_CTL_A, 8'h90);
    wr(acr_pkg::IDX_CTL_B, 8'h01);
    trig_flags <= 7'h01;
    expect_start(1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
